// ---- aspc_core.v ----
// How it works
// - while the break control bit is set the serial output is held low, and released it returns to idle framing.
// - received characters wait in a receive fifo and each read of the data word returns and removes the oldest.
// - a status bit shows at any time whether the receive fifo holds a character.
// - written characters go into a transmit fifo and a status bit shows whether it has room.
// - character length is five, six, seven or eight bits for both directions.
// - one or two stop bits end every transmitted frame.
// - parity is off, even, odd, stuck high or stuck low.
// - the bit rate is divided down from the one system clock.
// - divisor and frame format read back as written; the real rate is clock over sixteen times divisor.
// - the receive fifo is sixteen by twelve bits and the transmit fifo sixteen by eight bits.
// - a tick at sixteen times the bit rate drives both directions; the top rate is clock over sixteen.
// - start, stop and parity are added on transmit and stripped on receive, and a line break is detected.
`timescale 1ns/1ps
`include "aspc_map.vh"
module aspc_core #(
	parameter DIV_W = 16
) (
	input  wire        REF_CLK,
	input  wire        RST_B,
	input  wire [7:0]  ADDR,
	input  wire [31:0] WDATA,
	input  wire        WR,
	input  wire        RD,
	output reg  [31:0] RDATA,
	input  wire        RXD,
	output reg         TXD
);
	localparam TX_IDLE = 2'd0, TX_SHIFT = 2'd1, TX_STOP = 2'd2;
	localparam RX_IDLE = 2'd0, RX_SHIFT = 2'd1, RX_STOP = 2'd2;

	// data bits for a length code
	function [3:0] nbits;
		input [1:0] code;
		nbits = 4'd5 + {2'b00, code};
	endfunction

	// mask of the valid data bits for a length code
	function [7:0] dmask;
		input [1:0] code;
		dmask = 8'hFF >> (3'h3 - {1'b0, code});
	endfunction

	// parity bit over the valid data bits for a mode
	function par_bit;
		input [7:0] d;
		input [1:0] len;
		input [2:0] mode;
		reg   [7:0] m;
		begin
			m = dmask(len);
			case (mode)
			`ASPC_PAR_EVEN: par_bit = ^(d & m);
			`ASPC_PAR_ODD:  par_bit = ~^(d & m);
			`ASPC_PAR_HIGH: par_bit = 1'b1;
			default:        par_bit = 1'b0;
			endcase
		end
	endfunction

	reg [DIV_W-1:0] div_q;
	reg [5:0]       fmt_q;
	reg             brk_q;
	reg [DIV_W-1:0] bcnt_q;
	reg             tick_q;
	reg             rx_s1_q, rx_s2_q;
	wire [1:0]      len  = fmt_q[`ASPC_FMT_LEN_LSB+1:`ASPC_FMT_LEN_LSB];
	wire            stp2 = fmt_q[`ASPC_FMT_STOP2];
	wire [2:0]      pmod = fmt_q[`ASPC_FMT_PAR_LSB+2:`ASPC_FMT_PAR_LSB];

	////////////////////////////////////////////////////////////////
	// fifos
	wire       tx_empty, tx_full, rx_empty, rx_full;
	wire [7:0] tx_rd;
	wire [11:0] rx_rd;
	wire       tx_pop;
	reg        rx_push_q;
	reg [11:0] rx_ent_q;
	wire       rd_data_hit = RD && (ADDR == `ASPC_OFS_DATA);

	aspc_fifo #(.WIDTH(8), .DEPTH(16), .AW(4)) u_txf (
		.clk(REF_CLK), .rst_b(RST_B),
		.wr_en(WR && (ADDR == `ASPC_OFS_DATA)), .wr_data(WDATA[7:0]),
		.rd_en(tx_pop), .rd_data(tx_rd), .empty(tx_empty), .full(tx_full));

	aspc_fifo #(.WIDTH(12), .DEPTH(16), .AW(4)) u_rxf (
		.clk(REF_CLK), .rst_b(RST_B),
		.wr_en(rx_push_q), .wr_data(rx_ent_q),
		.rd_en(rd_data_hit), .rd_data(rx_rd), .empty(rx_empty), .full(rx_full));

	////////////////////////////////////////////////////////////////
	// baud tick at sixteen times the bit rate
	always @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			bcnt_q <= {DIV_W{1'b0}};
			tick_q <= 1'b0;
		end else if (div_q == {DIV_W{1'b0}}) begin
			tick_q <= 1'b0; // divisor zero stops the line
		end else if (bcnt_q >= div_q - 1'b1) begin
			bcnt_q <= {DIV_W{1'b0}};
			tick_q <= 1'b1;
		end else begin
			bcnt_q <= bcnt_q + 1'b1;
			tick_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////
	// transmitter
	reg [1:0] tx_st_q;
	reg [3:0] tx_os_q;
	reg [3:0] tx_bit_q;
	reg [9:0] tx_sh_q;

	// head goes straight into the shifter; held off during break
	assign tx_pop = (tx_st_q == TX_IDLE) && !tx_empty && !brk_q;

	always @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			tx_st_q   <= TX_IDLE;
			tx_os_q   <= 4'h0;
			tx_bit_q  <= 4'h0;
			tx_sh_q   <= 10'h3FF;
			TXD       <= 1'b1;
		end else begin
			TXD       <= brk_q ? 1'b0 : tx_sh_q[0];
			case (tx_st_q)
			TX_IDLE: begin
				tx_sh_q[0] <= 1'b1;
				if (tx_pop) begin
					// start, masked data, ones above so stop bits stay high
					tx_sh_q  <= (10'h3FF << (nbits(len) + 4'h1)) | {1'b0, tx_rd & dmask(len), 1'b0};
					if (pmod != `ASPC_PAR_OFF)
						tx_sh_q[nbits(len)+1] <= par_bit(tx_rd, len, pmod);
					tx_bit_q <= nbits(len) + ((pmod != `ASPC_PAR_OFF) ? 4'd1 : 4'd0);
					tx_os_q  <= 4'h0;
					tx_st_q  <= TX_SHIFT;
				end
			end
			TX_SHIFT: if (tick_q) begin
				tx_os_q <= tx_os_q + 4'h1;
				if (tx_os_q == 4'hF) begin
					tx_sh_q <= {1'b1, tx_sh_q[9:1]};
					if (tx_bit_q == 4'h0) begin
						tx_bit_q <= stp2 ? 4'd1 : 4'd0;
						tx_st_q  <= TX_STOP;
					end else
						tx_bit_q <= tx_bit_q - 4'h1;
				end
			end
			TX_STOP: if (tick_q) begin
				tx_os_q <= tx_os_q + 4'h1;
				if (tx_os_q == 4'hF) begin
					if (tx_bit_q == 4'h0)
						tx_st_q <= TX_IDLE;
					else
						tx_bit_q <= tx_bit_q - 4'h1;
				end
			end
			default: tx_st_q <= TX_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// receiver
	reg [1:0] rx_st_q;
	reg [3:0] rx_os_q;
	reg [3:0] rx_bit_q;
	reg [8:0] rx_sh_q;
	reg       rx_brk_q;
	reg [3:0] need;
	reg [7:0] rx_dat;
	reg       rx_par;
	reg       rx_zero;
	// only the bits of this frame count towards a break
	always @* begin
		need    = nbits(len) + ((pmod != `ASPC_PAR_OFF) ? 4'd1 : 4'd0);
		rx_dat  = rx_sh_q[7:0] >> (4'd9 - need);
		rx_par  = rx_sh_q[8];
		rx_zero = ((rx_sh_q >> (4'd9 - need)) == 9'h000);
	end

	always @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			rx_s1_q   <= 1'b1;
			rx_s2_q   <= 1'b1;
			rx_st_q   <= RX_IDLE;
			rx_os_q   <= 4'h0;
			rx_bit_q  <= 4'h0;
			rx_sh_q   <= 9'h000;
			rx_push_q <= 1'b0;
			rx_ent_q  <= 12'h000;
			rx_brk_q  <= 1'b0;
		end else begin
			rx_s1_q   <= RXD;
			rx_s2_q   <= rx_s1_q;
			rx_push_q <= 1'b0;
			case (rx_st_q)
			RX_IDLE: if (tick_q) begin
				if (!rx_s2_q) begin
					rx_os_q <= rx_os_q + 4'h1;
					if (rx_os_q == `ASPC_MID_TICK) begin
						rx_os_q  <= 4'h0;
						rx_bit_q <= 4'h0;
						rx_st_q  <= RX_SHIFT;
					end
				end else
					rx_os_q <= 4'h0;
			end
			RX_SHIFT: if (tick_q) begin
				rx_os_q <= rx_os_q + 4'h1;
				if (rx_os_q == 4'hF) begin
					rx_sh_q  <= {rx_s2_q, rx_sh_q[8:1]}; // shift in the sampled bit, lsb first; the start bit is never stored
					rx_bit_q <= rx_bit_q + 4'h1;
					if (rx_bit_q + 4'h1 == need)
						rx_st_q <= RX_STOP;
				end
			end
			RX_STOP: if (tick_q) begin
				rx_os_q <= rx_os_q + 4'h1;
				if (rx_os_q == 4'hF) begin
					// align for short frames
					rx_ent_q[7:0] <= (pmod == `ASPC_PAR_OFF) ? (rx_sh_q[8:1] >> (4'd8 - need)) : rx_dat;
					rx_ent_q[`ASPC_RXE_PAR_ERR] <= (pmod != `ASPC_PAR_OFF) &&
						(rx_par != par_bit(rx_dat, len, pmod));
					rx_ent_q[`ASPC_RXE_FRM_ERR] <= !rx_s2_q;
					rx_ent_q[`ASPC_RXE_BRK] <= !rx_s2_q && rx_zero;
					rx_ent_q[11] <= 1'b0;
					rx_brk_q  <= !rx_s2_q && rx_zero;
					rx_push_q <= !rx_full;
					rx_st_q   <= RX_IDLE;
				end
			end
			default: rx_st_q <= RX_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// register writes and registered read data
	always @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			div_q     <= `ASPC_RST_DIVISOR;
			fmt_q     <= `ASPC_RST_FORMAT;
			brk_q     <= 1'b0;
			RDATA     <= 32'h0000_0000;
		end else begin
			if (WR) begin
				case (ADDR)
				`ASPC_OFS_DIVISOR: div_q <= WDATA[DIV_W-1:0];
				`ASPC_OFS_FORMAT:  fmt_q <= WDATA[5:0];
				`ASPC_OFS_CONTROL: brk_q <= WDATA[`ASPC_CTL_BREAK];
				default: ;
				endcase
			end
			RDATA <= 32'h0000_0000;
			if (RD) begin
				case (ADDR)
				`ASPC_OFS_DATA:    RDATA <= rx_empty ? 32'hFFFF_FFFF : {20'h00000, rx_rd};
				`ASPC_OFS_STATUS:  RDATA <= {28'h0000000, rx_brk_q, (tx_st_q != TX_IDLE),
					!tx_full, !rx_empty};
				`ASPC_OFS_DIVISOR: RDATA <= {{(32-DIV_W){1'b0}}, div_q};
				`ASPC_OFS_FORMAT:  RDATA <= {26'h0, fmt_q};
				`ASPC_OFS_CONTROL: RDATA <= {31'h0, brk_q};
				default:           RDATA <= 32'h0000_0000;
				endcase
			end
		end
	end
endmodule

// ---- aspc_core_properties.sv ----
`timescale 1ns/1ps
`include "aspc_map.vh"
module aspc_chk (
	input wire        REF_CLK,
	input wire        RST_B,
	input wire [7:0]  ADDR,
	input wire [31:0] WDATA,
	input wire        WR,
	input wire        RD,
	input wire [31:0] RDATA,
	input wire        TXD
);
	reg        brk_q;
	reg [5:0]  fmt_q;
	reg [15:0] div_q;
	wire       r_dat = RD && ADDR == `ASPC_OFS_DATA;
	wire       r_st  = RD && ADDR == `ASPC_OFS_STATUS;
	wire       r_fmt = RD && ADDR == `ASPC_OFS_FORMAT;
	wire       r_div = RD && ADDR == `ASPC_OFS_DIVISOR;
	wire       r_hi  = RD && ADDR > `ASPC_OFS_CONTROL;
	default clocking @(posedge REF_CLK);
	endclocking
	default disable iff (!RST_B);
	////////////////
	// shadows of the writable registers
	always @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			brk_q <= 1'b0;
			fmt_q <= `ASPC_RST_FORMAT;
			div_q <= `ASPC_RST_DIVISOR;
		end else if (WR) begin
			if (ADDR == `ASPC_OFS_CONTROL)
				brk_q <= WDATA[0];
			if (ADDR == `ASPC_OFS_FORMAT)
				fmt_q <= WDATA[5:0];
			if (ADDR == `ASPC_OFS_DIVISOR)
				div_q <= WDATA[15:0];
		end
	end
	////////////////
	// read port relations
	property p_quiet; !$past(RD) |-> RDATA == 32'h0; endproperty
	property p_fmt; $past(r_fmt) |-> RDATA == {26'h0, $past(fmt_q)}; endproperty
	property p_div; $past(r_div) |-> RDATA == {16'h0, $past(div_q)}; endproperty
	property p_unmap; $past(r_hi) |-> RDATA == 32'h0; endproperty
	property p_stat; $past(r_st) |-> RDATA[31:4] == 28'h0; endproperty
	property p_word; $past(r_dat) |-> RDATA[31:11] == 21'h0 || RDATA == 32'hFFFFFFFF; endproperty
	// serial line relations
	property p_brk; brk_q && $past(brk_q) |-> !TXD; endproperty
	property p_low; $fell(TXD) |-> !TXD [*8]; endproperty
	property p_high; $rose(TXD) |-> TXD [*8]; endproperty
	a_quiet: assert property (p_quiet) else $error("read data not quiet");
	a_fmt: assert property (p_fmt) else $error("format readback");
	a_div: assert property (p_div) else $error("divisor readback");
	a_unmap: assert property (p_unmap) else $error("unmapped read");
	a_stat: assert property (p_stat) else $error("status spare bits");
	a_word: assert property (p_word) else $error("data word layout");
	a_brk: assert property (p_brk) else $error("break not low");
	a_low: assert property (p_low) else $error("short low bit");
	a_high: assert property (p_high) else $error("short high bit");
	c_brk: cover property (brk_q ##2 !TXD);
	c_perr: cover property ($past(r_dat) && RDATA[8]);
	c_start: cover property ($fell(TXD) && !brk_q);
endmodule

// ---- aspc_core_tb.sv ----
`timescale 1ns/1ps
`include "aspc_map.vh"
module aspc_core_tb;
	reg         ref_clk = 1'b0;
	reg         rst_b = 1'b0;
	reg  [7:0]  addr = 8'h00;
	reg  [31:0] wdata = 32'h0;
	reg         wr = 1'b0;
	reg         rd = 1'b0;
	wire [31:0] rdata;
	wire        rxd;
	wire        txd;
	integer     n_errors = 0;
	integer     tests_run = 0;
	integer     i;
	integer     j;
	integer     n;
	reg  [31:0] v;
	reg  [7:0]  c;
	reg  [7:0]  mk;
	reg         pb;
	reg         sb;
	reg         bad;
	time        t0;
	time        t1;
	always #10 ref_clk = ~ref_clk;
	aspc_core i_aspc_core (.REF_CLK(ref_clk), .RST_B(rst_b), .ADDR(addr), .WDATA(wdata),
		.WR(wr), .RD(rd), .RDATA(rdata), .RXD(rxd), .TXD(txd));
	aspc_peer #(.BIT_NS(640)) i_aspc_peer (.line_in(txd), .line_out(rxd));
	////////////////
	// register bus cycles
	task wr32(input [7:0] a, input [31:0] d);
		@(posedge ref_clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge ref_clk);
		wr <= 1'b0;
	endtask
	task rd32(input [7:0] a, output [31:0] d);
		@(posedge ref_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge ref_clk);
		rd <= 1'b0;
		@(posedge ref_clk);
		d = rdata;
	endtask
	task chk(input [31:0] e, input [31:0] g, input string nm);
		tests_run = tests_run + 1;
		if (g !== e) begin
			n_errors = n_errors + 1;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task rdchk(input [7:0] a, input [31:0] e, input string nm);
		rd32(a, v);
		chk(e, v, nm);
	endtask
	task wait_rx;
		v = 32'h0;
		for (j = 0; j < 400 && v[0] !== 1'b1; j = j + 1)
			rd32(`ASPC_OFS_STATUS, v);
		chk(32'h1, 32'(v[0]), "rx avail");
	endtask
	function pbit(input [7:0] d, input integer n, input integer m);
		reg [7:0] k;
		k = d & (8'hFF >> (8 - n));
		pbit = (m == 1) ? ^k : (m == 2) ? ~^k : (m == 3);
	endfunction
	task test_done;
		$display("checks %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	////////////////
	// hang guard, about three times the expected run
	initial begin
		#1600000;
		n_errors = n_errors + 1;
		test_done;
	end
	initial begin
		repeat (10) @(posedge ref_clk);
		rst_b <= 1'b1;
		rdchk(`ASPC_OFS_DIVISOR, 32'h1B, "divisor");
		rdchk(`ASPC_OFS_FORMAT, 32'h3, "format");
		rdchk(`ASPC_OFS_STATUS, 32'h2, "status");
		rdchk(`ASPC_OFS_DATA, 32'hFFFFFFFF, "empty data");
		rdchk(8'h14, 32'h0, "unmapped");
		wr32(`ASPC_OFS_DIVISOR, 32'h2);
		rdchk(`ASPC_OFS_DIVISOR, 32'h2, "divisor");
		$display("test registers done");
		// every length and parity mode, both ways, bad parity on odd steps from step 4 on
		for (i = 0; i < 20; i = i + 1) begin
			n = 5 + i % 4;
			mk = 8'hFF >> (8 - n);
			c = 8'hA5 ^ i[7:0];
			bad = i[0] && i >= 4;
			wr32(`ASPC_OFS_FORMAT, (i / 4) * 8 + i % 4);
			wr32(`ASPC_OFS_DATA, {24'h0, c});
			i_aspc_peer.get(n, i >= 4, v[7:0], pb, sb, t0);
			chk({24'h0, c & mk}, {24'h0, v[7:0]}, "tx char");
			chk(32'(pbit(c, n, i / 4)), 32'(pb), "tx parity");
			chk(32'h1, 32'(sb), "tx stop");
			i_aspc_peer.send(c, n, i >= 4, pbit(c, n, i / 4) ^ bad);
			wait_rx;
			rdchk(`ASPC_OFS_DATA, {23'h0, bad, c & mk}, "rx word");
		end
		$display("test formats done");
		// writes past full are dropped; two stop bits spacing
		wr32(`ASPC_OFS_FORMAT, 32'h7);
		fork
			begin
				for (i = 0; i < 20; i = i + 1)
					wr32(`ASPC_OFS_DATA, 32'h40 + i);
				rdchk(`ASPC_OFS_STATUS, 32'h4, "tx full");
			end
			for (j = 0; j < 17; j = j + 1) begin
				i_aspc_peer.get(8, 0, c, pb, sb, t1);
				chk(32'h40 + j, {24'h0, c}, "tx fifo");
				if (j > 0)
					chk(32'h1, 32'(t1 - t0 >= 7040 && t1 - t0 < 7240), "stop gap");
				t0 = t1;
			end
		join
		#2000;
		rdchk(`ASPC_OFS_STATUS, 32'h2, "tx drained");
		$display("test tx fifo done");
		// seventeen frames into a sixteen deep receive store
		wr32(`ASPC_OFS_FORMAT, 32'h3);
		for (i = 0; i < 17; i = i + 1)
			i_aspc_peer.send(8'h60 + i[7:0], 8, 0, 1'b0);
		for (i = 0; i < 16; i = i + 1)
			rdchk(`ASPC_OFS_DATA, 32'h60 + i, "rx fifo");
		rdchk(`ASPC_OFS_STATUS, 32'h2, "rx drained");
		$display("test rx fifo done");
		// break out for two frames, then break in
		wr32(`ASPC_OFS_CONTROL, 32'h1);
		repeat (2 * 11 * 32) @(posedge ref_clk);
		chk(32'h0, 32'(txd), "break line");
		wr32(`ASPC_OFS_CONTROL, 32'h0);
		repeat (4) @(posedge ref_clk);
		chk(32'h1, 32'(txd), "break off");
		i_aspc_peer.brk(22);
		rd32(`ASPC_OFS_STATUS, v);
		chk(32'h1, 32'(v[3]), "rx break");
		rdchk(`ASPC_OFS_DATA, 32'h600, "rx break word");
		$display("test break done");
		test_done;
	end
endmodule
bind aspc_core aspc_chk i_aspc_chk (.REF_CLK(REF_CLK), .RST_B(RST_B), .ADDR(ADDR), .WDATA(WDATA),
	.WR(WR), .RD(RD), .RDATA(RDATA), .TXD(TXD));

// ---- aspc_fifo.v ----
`timescale 1ns/1ps
// small synchronous fifo, registered read data always showing the head
module aspc_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 16,
	parameter AW    = 4
) (
	input  wire             clk,
	input  wire             rst_b,
	input  wire             wr_en,
	input  wire [WIDTH-1:0] wr_data,
	input  wire             rd_en,
	output reg  [WIDTH-1:0] rd_data,
	output wire             empty,
	output wire             full
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW:0]      wp_q;
	reg [AW:0]      rp_q;
	wire            wr_go;
	wire            rd_go;
	wire [AW:0]     rp_nxt;

	assign empty  = (wp_q == rp_q);
	assign full   = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
	assign wr_go  = wr_en && !full;
	assign rd_go  = rd_en && !empty;
	assign rp_nxt = rd_go ? rp_q + 1'b1 : rp_q;

	// storage write
	always @(posedge clk) begin
		if (wr_go)
			mem[wp_q[AW-1:0]] <= wr_data;
	end

	// pointers, and the head as it stands after this edge
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wp_q    <= {(AW+1){1'b0}};
			rp_q    <= {(AW+1){1'b0}};
			rd_data <= {WIDTH{1'b0}};
		end else begin
			if (wr_go)
				wp_q <= wp_q + 1'b1;
			if (rd_go)
				rp_q <= rp_nxt;
			// a write into the slot that becomes the head bypasses the array
			if (wr_go && (wp_q[AW-1:0] == rp_nxt[AW-1:0]))
				rd_data <= wr_data;
			else
				rd_data <= mem[rp_nxt[AW-1:0]];
		end
	end
endmodule

// ---- aspc_map.vh ----
`ifndef ASPC_MAP_VH
`define ASPC_MAP_VH
// register offsets (byte addresses, one word each)
`define ASPC_OFS_DATA     8'h00
`define ASPC_OFS_STATUS   8'h04
`define ASPC_OFS_DIVISOR  8'h08
`define ASPC_OFS_FORMAT   8'h0C
`define ASPC_OFS_CONTROL  8'h10
// status bits
`define ASPC_ST_RX_AVAIL  0
`define ASPC_ST_TX_SPACE  1
`define ASPC_ST_TX_BUSY   2
`define ASPC_ST_RX_BREAK  3
// format fields
`define ASPC_FMT_LEN_LSB  0
`define ASPC_FMT_STOP2    2
`define ASPC_FMT_PAR_LSB  3
// control bits
`define ASPC_CTL_BREAK    0
// character length codes
`define ASPC_LEN_FIVE     2'h0
`define ASPC_LEN_SIX      2'h1
`define ASPC_LEN_SEVEN    2'h2
`define ASPC_LEN_EIGHT    2'h3
// parity codes
`define ASPC_PAR_OFF      3'h0
`define ASPC_PAR_EVEN     3'h1
`define ASPC_PAR_ODD      3'h2
`define ASPC_PAR_HIGH     3'h3
`define ASPC_PAR_LOW      3'h4
// reset values
`define ASPC_RST_DIVISOR  16'h001B
`define ASPC_RST_FORMAT   6'h03
// oversampling
`define ASPC_OVERSAMPLE   16
`define ASPC_MID_TICK     4'h7
// receive entry flag positions
`define ASPC_RXE_PAR_ERR  8
`define ASPC_RXE_FRM_ERR  9
`define ASPC_RXE_BRK      10
`endif

// ---- aspc_peer.sv ----
`timescale 1ns/1ps
module aspc_peer #(
	parameter BIT_NS = 640
) (
	input  wire line_in,
	output reg  line_out
);
	// line idles high
	initial line_out = 1'b1;
	////////////////
	// frame out: start, data lsb first, parity, stop
	task send(input [7:0] d, input integer n, input integer hp, input p);
		integer k;
		#3;
		line_out = 1'b0;
		#(BIT_NS);
		for (k = 0; k < n + hp; k = k + 1) begin
			line_out = (k < n) ? d[k] : p;
			#(BIT_NS);
		end
		line_out = 1'b1;
		#(BIT_NS);
	endtask
	// line held low over whole frames
	task brk(input integer nb);
		#3;
		line_out = 1'b0;
		#(nb * BIT_NS);
		line_out = 1'b1;
		#(2 * BIT_NS);
	endtask
	// frame in, sampled mid bit; returns at mid stop bit
	task get(input integer n, input integer hp, output [7:0] d, output pb, output sb, output time t);
		integer k;
		d = 8'h00;
		pb = 1'b0;
		@(negedge line_in);
		t = $time;
		#(BIT_NS / 2);
		for (k = 0; k < n; k = k + 1) begin
			#(BIT_NS);
			d[k] = line_in;
		end
		if (hp) begin
			#(BIT_NS);
			pb = line_in;
		end
		#(BIT_NS);
		sb = line_in;
	endtask
endmodule
